// [flash_protection_pkg.sv]
/*
 Constants for the flash protection sequencer: special function register
 addresses, command codes, protection area layout, reset values and timing.
 Assumes a 125 MHz core clock and a 62 kB flash of 512-byte pages.
*/
package flash_protection_pkg;
    // register addresses
    localparam logic [7:0] SFR_FLASH_COMMAND = 8'hB9;
    localparam logic [7:0] SFR_FLASH_ACCESS_KEY = 8'hBA;
    localparam logic [7:0] SFR_PROTECTION_KEY_ENTRY = 8'hBB;
    localparam logic [7:0] SFR_FLASH_DATA_BYTE = 8'hBC;
    localparam logic [7:0] SFR_FLASH_ADDR_LOW = 8'hC6;
    localparam logic [7:0] SFR_FLASH_ADDR_HIGH = 8'hC7;
    // command codes
    localparam logic [7:0] CMD_WRITE_BYTE = 8'h01;
    localparam logic [7:0] CMD_ERASE_PAGE = 8'h02;
    localparam logic [7:0] CMD_ERASE_ALL = 8'h03;
    localparam logic [7:0] CMD_READ_BYTE = 8'h04;
    localparam logic [7:0] CMD_PROTECT = 8'h08;
    localparam logic [7:0] EMU_LOAD_SCRATCH = 8'h49;
    localparam logic [7:0] EMU_STORE_SFR = 8'h46;
    // key values and reset values
    localparam logic [7:0] ACCESS_KEY_VALUE = 8'h3B;
    localparam logic [7:0] ERASED_BYTE = 8'hFF;
    localparam logic [7:0] PROT_KEY_CLEARED = 8'h00;
    localparam logic [7:0] ACCESS_KEY_RESET = 8'hFF;
    localparam logic [7:0] PROT_KEY_RESET = 8'hFF;
    localparam logic [7:0] DATA_RESET = 8'h00;
    localparam logic [7:0] ADDR_RESET = 8'h00;
    localparam logic [7:0] CMD_RESET = 8'h00;
    // protection area layout
    localparam logic [7:0] PROT_AREA_HIGH = 8'hF7;
    localparam logic [7:0] PROT_FIRST_LOW = 8'hEB;
    localparam logic [7:0] READ_GUARD_FIRST_LOW = 8'hEC;
    localparam logic [7:0] WRITE_GUARD_FIRST_LOW = 8'hF0;
    localparam int PROT_BYTES = 21;
    localparam logic [4:0] PROT_KEY_INDEX = 5'h00;
    localparam logic [4:0] LAST_GUARD_INDEX = 5'h14;
    localparam int LAST_PAGE_BIT = 3;
    localparam int WATCHDOG_LOCK_ENABLE_BIT = 7;
    localparam logic [6:0] LAST_PAGE = 7'h7B;
    localparam int PAGE_SHIFT = 9;
    // timing, figures in their own units
    localparam int CLK_PERIOD_NS = 8;
    localparam int BYTE_WRITE_US = 30;
    localparam int PAGE_ERASE_MS = 20;
    localparam int FULL_ERASE_MS = 2500;
    localparam int READ_BYTE_NS = 100;
    localparam int TIMER_W = 29;
    localparam int BYTE_WRITE_CYCLES = BYTE_WRITE_US * 1000 / CLK_PERIOD_NS;
    localparam int READ_BYTE_CYCLES = READ_BYTE_NS / CLK_PERIOD_NS;
endpackage

// [busy_timer.sv]
/*
 Busy timer: counts a loaded number of cycles and pulses done at the end.
 Assumes start arrives only while idle.
*/
`timescale 1ns/1ns
`default_nettype none
module busy_timer #(
    parameter int W = 29
) (
    // clock and reset
    input wire logic clk,
    input wire logic reset,
    // control
    input wire logic start,
    input wire logic [W-1:0] length,
    // status
    output logic busy,
    output logic done
);
    logic [W-1:0] count;

    // down counter, busy for exactly length cycles
    always_ff @(posedge clk) begin
        if (reset) begin
            count <= '0;
        end else if (start) begin
            count <= length;
        end else if (count != '0) begin
            count <= count - W'(1);
        end
    end

    assign busy = (count != '0);
    assign done = (count == W'(1));

    ended_on_one_a: assert property (@(posedge clk) disable iff (reset)
        done |=> !busy) else $error("timer still busy after done");
endmodule // busy_timer
`default_nettype wire

// [flash_protection_sequencer.sv]
/*
 Flash protection sequencer: keyed command register, protection byte
 programming, page guards, one-time key, watchdog lock bit and core stall.
 Assumes the flash array answers flash_rdata combinationally from flash_addr
 and performs the write and erase pulses it is given.
*/
`timescale 1ns/1ns
`default_nettype none
module flash_protection_sequencer #(
    parameter int PAGE_ERASE_CYCLES = flash_protection_pkg::PAGE_ERASE_MS * (1000000 /
        flash_protection_pkg::CLK_PERIOD_NS),
    parameter int FULL_ERASE_CYCLES = flash_protection_pkg::FULL_ERASE_MS * (1000000 /
        flash_protection_pkg::CLK_PERIOD_NS)
) (
    // clock and reset
    input wire logic clk,
    input wire logic reset,
    // core special function register port
    input wire logic [7:0] sfr_addr,
    input wire logic sfr_wr,
    input wire logic sfr_rd,
    input wire logic [7:0] sfr_wdata,
    output logic [7:0] sfr_rdata,
    // download kernel commands
    input wire logic emu_valid,
    input wire logic [7:0] emu_code,
    input wire logic [7:0] emu_data,
    // pin
    input wire logic download_enable_pin_n,
    // flash array
    output logic [15:0] flash_addr,
    output logic [7:0] flash_wdata,
    output logic flash_write,
    output logic flash_erase_page,
    output logic flash_erase_all,
    input wire logic [7:0] flash_rdata,
    // status
    output logic core_hold,
    output logic download_mode,
    output logic protection_enabled,
    output logic watchdog_lock_enable
);
    typedef enum logic [1:0] {S_LOAD_ADDR, S_LOAD_CAP, S_IDLE, S_BUSY} seq_state_e;

    seq_state_e state;
    logic [4:0] load_index;
    logic [7:0] active [flash_protection_pkg::PROT_BYTES];
    logic [7:0] stored [flash_protection_pkg::PROT_BYTES];
    logic [7:0] flash_command, flash_access_key, protection_key_entry;
    logic [7:0] flash_data_byte, flash_addr_low, flash_addr_high, emulator_scratch;
    logic pin_meta, pin_sync;
    logic read_pending;
    logic emu_store, reg_wr, cmd_wr;
    logic [7:0] reg_addr, reg_data;
    logic [6:0] page;
    logic [4:0] prot_index;
    logic in_prot_area, page_ok, key_ok, wp_hit, rp_hit, prot_key_ok, accept;
    logic [flash_protection_pkg::TIMER_W-1:0] op_len;
    logic timer_busy, timer_done;

    // index of the write/erase guard byte for a page
    function automatic logic [4:0] wp_index(input logic [6:0] pg);
        return 5'(flash_protection_pkg::WRITE_GUARD_FIRST_LOW - flash_protection_pkg::PROT_FIRST_LOW)
            + {1'b0, pg[6:3]};
    endfunction

    // index of the read guard byte for a page's four-page group
    function automatic logic [4:0] rp_index(input logic [6:0] pg);
        return 5'(flash_protection_pkg::READ_GUARD_FIRST_LOW - flash_protection_pkg::PROT_FIRST_LOW)
            + {3'b000, pg[6:5]};
    endfunction

    // the pin comes from outside: two flops before anything looks at it
    always_ff @(posedge clk) begin
        if (reset) begin
            pin_meta <= 1'b1;
            pin_sync <= 1'b1;
        end else begin
            pin_meta <= download_enable_pin_n;
            pin_sync <= pin_meta;
        end
    end

    // register write source: core, or download kernel store of the scratch
    assign emu_store = download_mode && emu_valid && (emu_code == flash_protection_pkg::EMU_STORE_SFR);
    assign reg_wr = (sfr_wr || emu_store) && (state == S_IDLE);
    assign reg_addr = sfr_wr ? sfr_addr : emu_data;
    assign reg_data = sfr_wr ? sfr_wdata : emulator_scratch;
    assign cmd_wr = reg_wr && (reg_addr == flash_protection_pkg::SFR_FLASH_COMMAND);

    // scratch loaded by the download kernel
    always_ff @(posedge clk) begin
        if (reset) begin
            emulator_scratch <= flash_protection_pkg::DATA_RESET;
        end else if (download_mode && emu_valid && (emu_code == flash_protection_pkg::EMU_LOAD_SCRATCH)) begin
            emulator_scratch <= emu_data;
        end
    end

    // guards decoded from the image latched at reset
    assign protection_enabled = !active[flash_protection_pkg::LAST_GUARD_INDEX][flash_protection_pkg::LAST_PAGE_BIT];
    assign watchdog_lock_enable = !active[flash_protection_pkg::LAST_GUARD_INDEX][flash_protection_pkg::WATCHDOG_LOCK_ENABLE_BIT];
    assign page = flash_addr_high[7:flash_protection_pkg::PAGE_SHIFT - 8]; // address bits 15 down to the page shift
    assign page_ok = (page <= flash_protection_pkg::LAST_PAGE);
    assign in_prot_area = (flash_addr_high == flash_protection_pkg::PROT_AREA_HIGH)
        && (flash_addr_low >= flash_protection_pkg::PROT_FIRST_LOW);
    assign wp_hit = protection_enabled && !active[wp_index(page)][page[2:0]];
    assign rp_hit = protection_enabled && !in_prot_area && !active[rp_index(page)][page[4:2]];
    assign prot_index = 5'(flash_addr_low - flash_protection_pkg::PROT_FIRST_LOW);
    assign key_ok = (flash_access_key == flash_protection_pkg::ACCESS_KEY_VALUE);
    assign prot_key_ok = (active[flash_protection_pkg::PROT_KEY_INDEX] == flash_protection_pkg::ERASED_BYTE)
        || (protection_key_entry == active[flash_protection_pkg::PROT_KEY_INDEX]);

    // acceptance of the command being written, and its busy length
    always_comb begin
        accept = 1'b0;
        op_len = '0;
        if (reg_data == flash_protection_pkg::CMD_PROTECT) begin
            accept = key_ok && prot_key_ok && !download_mode
                && (flash_addr_low >= flash_protection_pkg::PROT_FIRST_LOW)
                && ((prot_index != flash_protection_pkg::PROT_KEY_INDEX)
                    || (stored[flash_protection_pkg::PROT_KEY_INDEX] == flash_protection_pkg::ERASED_BYTE));
            op_len = flash_protection_pkg::TIMER_W'(flash_protection_pkg::BYTE_WRITE_CYCLES);
        end else if (reg_data == flash_protection_pkg::CMD_WRITE_BYTE) begin
            accept = key_ok && page_ok && !wp_hit && !in_prot_area;
            op_len = flash_protection_pkg::TIMER_W'(flash_protection_pkg::BYTE_WRITE_CYCLES);
        end else if (reg_data == flash_protection_pkg::CMD_ERASE_PAGE) begin
            accept = key_ok && page_ok && !wp_hit;
            op_len = flash_protection_pkg::TIMER_W'(PAGE_ERASE_CYCLES);
        end else if (reg_data == flash_protection_pkg::CMD_ERASE_ALL) begin
            accept = key_ok;
            op_len = flash_protection_pkg::TIMER_W'(FULL_ERASE_CYCLES);
        end else if (reg_data == flash_protection_pkg::CMD_READ_BYTE) begin
            accept = key_ok && page_ok && !rp_hit;
            op_len = flash_protection_pkg::TIMER_W'(flash_protection_pkg::READ_BYTE_CYCLES);
        end
        accept = accept && cmd_wr;
    end

    // busy time of the running operation
    busy_timer #(.W(flash_protection_pkg::TIMER_W)) u_busy (
        .clk(clk),
        .reset(reset),
        .start(accept),
        .length(op_len),
        .busy(timer_busy),
        .done(timer_done)
    );

    // sequence: load the protection image after reset, then serve commands
    always_ff @(posedge clk) begin
        if (reset) begin
            state <= S_LOAD_ADDR;
            load_index <= '0;
            download_mode <= 1'b0;
        end else begin
            case (state)
                S_LOAD_ADDR: begin
                    state <= S_LOAD_CAP;
                end
                S_LOAD_CAP: begin
                    if (load_index == flash_protection_pkg::LAST_GUARD_INDEX) begin
                        state <= S_IDLE;
                        download_mode <= !pin_sync;
                    end else begin
                        load_index <= load_index + 5'h01;
                        state <= S_LOAD_ADDR;
                    end
                end
                S_IDLE: begin
                    if (accept) begin
                        state <= S_BUSY;
                    end
                end
                default: begin
                    if (timer_done) begin
                        state <= S_IDLE;
                    end
                end
            endcase
        end
    end

    assign core_hold = (state != S_IDLE);

    // protection image: active copy only at reset, stored copy tracks flash
    always_ff @(posedge clk) begin
        if (state == S_LOAD_CAP) begin
            active[load_index] <= flash_rdata;
            stored[load_index] <= flash_rdata;
        end else if (accept && (reg_data == flash_protection_pkg::CMD_PROTECT)) begin
            stored[prot_index] <= stored[prot_index] & flash_data_byte;
        end else if (accept && ((reg_data == flash_protection_pkg::CMD_ERASE_ALL)
            || ((reg_data == flash_protection_pkg::CMD_ERASE_PAGE) && (page == flash_protection_pkg::LAST_PAGE)))) begin
            for (int i = 0; i < flash_protection_pkg::PROT_BYTES; i++) begin
                stored[i] <= flash_protection_pkg::ERASED_BYTE;
            end
        end
    end

    // flash array strobes and address
    always_ff @(posedge clk) begin
        if (reset) begin
            flash_addr <= 16'h0000;
            flash_wdata <= 8'hFF;
            flash_write <= 1'b0;
            flash_erase_page <= 1'b0;
            flash_erase_all <= 1'b0;
        end else begin
            flash_write <= accept && ((reg_data == flash_protection_pkg::CMD_PROTECT)
                || (reg_data == flash_protection_pkg::CMD_WRITE_BYTE));
            flash_erase_page <= accept && (reg_data == flash_protection_pkg::CMD_ERASE_PAGE);
            flash_erase_all <= accept && (reg_data == flash_protection_pkg::CMD_ERASE_ALL);
            if (state == S_LOAD_ADDR) begin
                flash_addr <= {flash_protection_pkg::PROT_AREA_HIGH, flash_protection_pkg::PROT_FIRST_LOW + {3'b000, load_index}};
            end else if (accept && (reg_data == flash_protection_pkg::CMD_PROTECT)) begin
                flash_addr <= {flash_protection_pkg::PROT_AREA_HIGH, flash_addr_low};
                flash_wdata <= flash_data_byte;
            end else if (accept) begin
                flash_addr <= {flash_addr_high, flash_addr_low};
                flash_wdata <= flash_data_byte;
            end
        end
    end

    // command, key and address registers written by the core
    always_ff @(posedge clk) begin
        if (reset) begin
            flash_command <= flash_protection_pkg::CMD_RESET;
            flash_access_key <= flash_protection_pkg::ACCESS_KEY_RESET;
            protection_key_entry <= flash_protection_pkg::PROT_KEY_RESET;
            flash_addr_low <= flash_protection_pkg::ADDR_RESET;
            flash_addr_high <= flash_protection_pkg::ADDR_RESET;
        end else if (cmd_wr) begin
            flash_command <= reg_data;
            flash_access_key <= flash_protection_pkg::ACCESS_KEY_RESET;
            if (reg_data == flash_protection_pkg::CMD_PROTECT) begin
                protection_key_entry <= flash_protection_pkg::PROT_KEY_CLEARED;
            end
        end else if (reg_wr) begin
            if (reg_addr == flash_protection_pkg::SFR_FLASH_ACCESS_KEY) begin
                flash_access_key <= reg_data;
            end else if (reg_addr == flash_protection_pkg::SFR_PROTECTION_KEY_ENTRY) begin
                protection_key_entry <= reg_data;
            end else if (reg_addr == flash_protection_pkg::SFR_FLASH_ADDR_LOW) begin
                flash_addr_low <= reg_data;
            end else if (reg_addr == flash_protection_pkg::SFR_FLASH_ADDR_HIGH) begin
                flash_addr_high <= reg_data;
            end
        end
    end

    // data register: written by the core, loaded at the end of a read
    always_ff @(posedge clk) begin
        if (reset) begin
            flash_data_byte <= flash_protection_pkg::DATA_RESET;
            read_pending <= 1'b0;
        end else begin
            if (accept) begin
                read_pending <= (reg_data == flash_protection_pkg::CMD_READ_BYTE);
            end else if (timer_done) begin
                read_pending <= 1'b0;
            end
            if (timer_done && read_pending) begin
                flash_data_byte <= flash_rdata;
            end else if (reg_wr && (reg_addr == flash_protection_pkg::SFR_FLASH_DATA_BYTE)) begin
                flash_data_byte <= reg_data;
            end
        end
    end

    // register read port, unmapped addresses read zero
    always_ff @(posedge clk) begin
        if (reset) begin
            sfr_rdata <= 8'h00;
        end else if (sfr_rd) begin
            if (sfr_addr == flash_protection_pkg::SFR_FLASH_COMMAND) begin
                sfr_rdata <= flash_command;
            end else if (sfr_addr == flash_protection_pkg::SFR_FLASH_ACCESS_KEY) begin
                sfr_rdata <= flash_access_key;
            end else if (sfr_addr == flash_protection_pkg::SFR_PROTECTION_KEY_ENTRY) begin
                sfr_rdata <= protection_key_entry;
            end else if (sfr_addr == flash_protection_pkg::SFR_FLASH_DATA_BYTE) begin
                sfr_rdata <= flash_data_byte;
            end else if (sfr_addr == flash_protection_pkg::SFR_FLASH_ADDR_LOW) begin
                sfr_rdata <= flash_addr_low;
            end else if (sfr_addr == flash_protection_pkg::SFR_FLASH_ADDR_HIGH) begin
                sfr_rdata <= flash_addr_high;
            end else begin
                sfr_rdata <= 8'h00;
            end
        end
    end

    // checks
    default clocking cb @(posedge clk); endclocking
    default disable iff (reset);

    key_entry_clear_a: assert property (cmd_wr && reg_data == flash_protection_pkg::CMD_PROTECT
        |=> protection_key_entry == flash_protection_pkg::PROT_KEY_CLEARED) else $error("key entry not cleared");
    protect_addr_high_a: assert property (accept && reg_data == flash_protection_pkg::CMD_PROTECT
        |=> flash_write && flash_addr[15:8] == flash_protection_pkg::PROT_AREA_HIGH) else $error("bad protect address");
    no_access_key_a: assert property (cmd_wr && !key_ok
        |=> !flash_write && !flash_erase_page && !flash_erase_all) else $error("unkeyed command ran");
    download_refuse_a: assert property (cmd_wr && download_mode && reg_data == flash_protection_pkg::CMD_PROTECT
        |=> !flash_write) else $error("protection programmed in download mode");
    key_once_a: assert property (cmd_wr && reg_data == flash_protection_pkg::CMD_PROTECT
        && flash_addr_low == flash_protection_pkg::PROT_FIRST_LOW
        && stored[flash_protection_pkg::PROT_KEY_INDEX] != flash_protection_pkg::ERASED_BYTE
        |=> !flash_write) else $error("key programmed twice");
    core_held_a: assert property (flash_write |-> core_hold ##1 core_hold[*2]) else $error("core not held");
    image_stable_a: assert property (state == S_IDLE
        |=> $stable(active[flash_protection_pkg::LAST_GUARD_INDEX])) else $error("image changed before reset");
    scheme_off_a: assert property (cmd_wr && reg_data == flash_protection_pkg::CMD_WRITE_BYTE && key_ok
        && !protection_enabled && page_ok && !in_prot_area |=> flash_write) else $error("unguarded write refused");
    prot_bytes_read_a: assert property (cmd_wr && reg_data == flash_protection_pkg::CMD_READ_BYTE && key_ok
        && in_prot_area |=> core_hold) else $error("protection bytes unreadable");
    write_guard_a: assert property (cmd_wr && wp_hit && reg_data == flash_protection_pkg::CMD_WRITE_BYTE
        |=> !flash_write) else $error("guarded page written");
    mode_stable_a: assert property (state == S_IDLE |=> $stable(download_mode)) else $error("mode changed");

    // a taken protection write not yet finished; its busy time is too long for a delay range
    logic protect_running;
    always_ff @(posedge clk) begin
        if (reset) begin
            protect_running <= 1'b0;
        end else if (accept && (reg_data == flash_protection_pkg::CMD_PROTECT)) begin
            protect_running <= 1'b1;
        end else if (timer_done) begin
            protect_running <= 1'b0;
        end
    end
    protect_done_c: cover property (protect_running && timer_done);
    erase_all_c: cover property (flash_erase_all);
    read_back_c: cover property (read_pending && timer_done);
    download_c: cover property (download_mode && emu_store);
endmodule // flash_protection_sequencer
`default_nettype wire

// [flash_array_model.sv]
/*
 Flash array model: 64 kB of bytes, all erased to FF at start.
 Assumes one-cycle program and erase strobes from the sequencer.
*/
`timescale 1ns/1ns
`default_nettype none
module flash_array_model (
    // sequencer side
    input wire logic clk,
    input wire logic [15:0] addr,
    input wire logic [7:0] wdata,
    input wire logic wr,
    input wire logic erase_page,
    input wire logic erase_all,
    output logic [7:0] rdata
);
    logic [7:0] mem [0:65535];
    // programming only clears bits, erase sets them back
    always @(posedge clk) begin
        if (wr) mem[addr] <= mem[addr] & wdata;
        if (erase_page) for (int i = 0; i < 512; i++) mem[{addr[15:9], 9'h000} + 16'(i)] <= 8'hFF;
        if (erase_all) for (int i = 0; i < 65536; i++) mem[i] <= 8'hFF;
    end
    assign rdata = mem[addr];
    initial for (int i = 0; i < 65536; i++) mem[i] = 8'hFF;
endmodule // flash_array_model
`default_nettype wire

// [tb_flash_protection_sequencer.sv]
/*
 Testbench: plays the core on the register port and download commands.
 Assumes the flash model answers reads in the same cycle.
*/
`timescale 1ns/1ns
`default_nettype none
module tb_flash_protection_sequencer;
    logic clk = 0, reset = 1, sfr_wr = 0, sfr_rd = 0, emu_valid = 0, download_enable_pin_n = 1;
    logic [7:0] sfr_addr = 8'h00, sfr_wdata = 8'h00, emu_code = 8'h00, emu_data = 8'h00;
    logic [7:0] sfr_rdata, flash_wdata, flash_rdata;
    logic [15:0] flash_addr;
    logic flash_write, flash_erase_page, flash_erase_all, core_hold, download_mode;
    logic protection_enabled, watchdog_lock_enable, hold;
    int fails = 0, tests_run = 0, writes = 0, cycles = 0, n;
    // clock
    always #4 clk = ~clk;
    // program pulse counter and run ceiling
    always @(posedge clk) begin
        writes <= writes + ((flash_write === 1'b1) ? 1 : 0);
        cycles <= cycles + 1;
        if (cycles == 40000) begin
            fails++;
            test_done();
        end
    end
    flash_protection_sequencer #(.PAGE_ERASE_CYCLES(50), .FULL_ERASE_CYCLES(80)) dut (.clk, .reset,
        .sfr_addr, .sfr_wr, .sfr_rd, .sfr_wdata, .sfr_rdata, .emu_valid, .emu_code, .emu_data,
        .download_enable_pin_n, .flash_addr, .flash_wdata, .flash_write, .flash_erase_page,
        .flash_erase_all, .flash_rdata, .core_hold, .download_mode, .protection_enabled,
        .watchdog_lock_enable);
    flash_array_model fa (.clk, .addr(flash_addr), .wdata(flash_wdata), .wr(flash_write),
        .erase_page(flash_erase_page), .erase_all(flash_erase_all), .rdata(flash_rdata));
    task check(input logic [15:0] seen, input logic [15:0] exp);
        tests_run++;
        if (seen !== exp) begin
            fails++;
            $display("unexpected at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask
    task wr(input logic [7:0] a, input logic [7:0] d);
        @(negedge clk);
        sfr_addr = a;
        sfr_wdata = d;
        sfr_wr = 1;
        @(negedge clk);
        sfr_wr = 0;
    endtask
    task rd_check(input logic [7:0] a, input logic [7:0] exp);
        @(negedge clk);
        sfr_addr = a;
        sfr_rd = 1;
        @(negedge clk);
        sfr_rd = 0;
        check(sfr_rdata, exp);
    endtask
    task emu(input logic [7:0] c, input logic [7:0] d);
        @(negedge clk);
        emu_code = c;
        emu_data = d;
        emu_valid = 1;
        @(negedge clk);
        emu_valid = 0;
    endtask
    task wait_idle;
        for (int i = 0; i < 5000 && core_hold !== 1'b0; i++) @(negedge clk);
    endtask
    // address, access key, command; high byte is a decoy for protect
    task cmd(input logic [7:0] hi, input logic [7:0] lo, input logic [7:0] code, input logic [7:0] key);
        wr(8'hC7, hi);
        wr(8'hC6, lo);
        wr(8'hBA, key);
        wr(8'hB9, code);
        hold = core_hold;
        wait_idle();
    endtask
    task do_reset(input logic pin);
        download_enable_pin_n = pin;
        reset = 1;
        repeat (16) @(negedge clk);
        reset = 0;
        wait_idle();
    endtask
    task t_reset_values;
        rd_check(8'hBA, 8'hFF);
        rd_check(8'hBB, 8'hFF);
        rd_check(8'hBC, 8'h00);
        rd_check(8'hC6, 8'h00);
        rd_check(8'h80, 8'h00);
        check(protection_enabled, 1'b0);
        check(watchdog_lock_enable, 1'b0);
        wr(8'hBC, 8'h5A);
        cmd(8'h00, 8'h20, 8'h01, 8'h3B);
        check(fa.mem[16'h0020], 8'h5A);
    endtask
    task t_enable;
        wr(8'hBC, 8'h00);
        cmd(8'h12, 8'hFE, 8'h08, 8'h00);
        check(fa.mem[16'hF7FE], 8'hFF);
        check(hold, 1'b0);
        rd_check(8'hBB, 8'h00);
        rd_check(8'hB9, 8'h08);
        rd_check(8'hC7, 8'h12);
        n = writes;
        wr(8'hBC, 8'hFE);
        cmd(8'h12, 8'hFE, 8'h08, 8'h3B);
        check(hold, 1'b1);
        check(16'(writes - n), 16'h0001);
        check(fa.mem[16'hF7FE], 8'hFE);
        wr(8'hBC, 8'h77);
        cmd(8'h12, 8'hFF, 8'h08, 8'h3B);
        check(protection_enabled, 1'b0);
        do_reset(1'b1);
        check(protection_enabled, 1'b1);
        check(watchdog_lock_enable, 1'b1);
    endtask
    task prot(input logic [7:0] lo, input logic [7:0] d);
        wr(8'hBC, d);
        cmd(8'h12, lo, 8'h08, 8'h3B);
    endtask
    task t_one_key;
        prot(8'hF0, 8'hFE);
        prot(8'hEC, 8'hFE);
        check(fa.mem[16'hF7EC], 8'hFE);
        prot(8'hEB, 8'hA3);
        prot(8'hEB, 8'h5C);
        check(fa.mem[16'hF7EB], 8'hA3);
        do_reset(1'b1);
        prot(8'hF1, 8'hFE);
        check(fa.mem[16'hF7F1], 8'hFF);
        wr(8'hBB, 8'hA3);
        prot(8'hF1, 8'hFE);
        check(fa.mem[16'hF7F1], 8'hFE);
    endtask
    task t_guards;
        wr(8'hBC, 8'h55);
        cmd(8'h06, 8'h00, 8'h04, 8'h3B);
        rd_check(8'hBC, 8'h55);
        cmd(8'h08, 8'h00, 8'h04, 8'h3B);
        rd_check(8'hBC, 8'hFF);
        cmd(8'hF7, 8'hEC, 8'h04, 8'h3B);
        rd_check(8'hBC, 8'hFE);
        wr(8'hBC, 8'h00);
        cmd(8'h00, 8'h10, 8'h01, 8'h3B);
        check(fa.mem[16'h0010], 8'hFF);
        cmd(8'h02, 8'h10, 8'h01, 8'h3B);
        check(fa.mem[16'h0210], 8'h00);
        cmd(8'h02, 8'h10, 8'h02, 8'h3B);
        check(hold, 1'b1);
        check(fa.mem[16'h0210], 8'hFF);
        cmd(8'h00, 8'h20, 8'h02, 8'h3B);
        check(fa.mem[16'h0020], 8'h5A);
    endtask
    task t_download;
        do_reset(1'b0);
        check(download_mode, 1'b1);
        emu(8'h49, 8'h5A);
        emu(8'h46, 8'hBC);
        rd_check(8'hBC, 8'h5A);
        wr(8'hBB, 8'hA3);
        cmd(8'h12, 8'hF2, 8'h08, 8'h3B);
        check(fa.mem[16'hF7F2], 8'hFF);
        cmd(8'h00, 8'h00, 8'h03, 8'h3B);
        check(fa.mem[16'hF7EB], 8'hFF);
    endtask
    task test_done;
        $display("fails=%0d tests_run=%0d", fails, tests_run);
        if (fails == 0 && tests_run > 0) $display("Run complete: PASS");
        else $display("Run complete: FAIL");
        $finish;
    endtask
    // main sequence
    initial begin
        repeat (16) @(negedge clk);
        reset = 0;
        wait_idle();
        t_reset_values();
        t_enable();
        t_one_key();
        t_guards();
        t_download();
        test_done();
    end
endmodule // tb_flash_protection_sequencer
`default_nettype wire
